// ==== hdl/iss_pkg.sv ====
package iss_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam int ISS_ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_SLOT0 = 8'h08;
  localparam logic [7:0] OFS_ALT_ID = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // ---------------------------------------------------------------
  // Status field positions
  // ---------------------------------------------------------------
  localparam int STA_BIT = 14;
  localparam int REPS_BIT = 13;
  localparam int ID_LSB = 11;
  localparam int SS_BIT = 10;
  localparam int GC_LSB = 8;
  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int CTL_SLV_EN = 0;
  localparam int CTL_GC_EN = 1;
  localparam int CTL_STOP_IE = 2;
  localparam int CTL_GC_CLR = 3;
  localparam int CTL_W = 3;
  // ---------------------------------------------------------------
  // Interrupt bits
  // ---------------------------------------------------------------
  localparam int IRQ_SS = 0;
  localparam int IRQ_REPS = 1;
  localparam int IRQ_GC = 2;
  localparam int IRQ_W = 3;
  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [CTL_W-1:0] CTL_RST = 3'h0;
  localparam logic [6:0] SLOT_RST = 7'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] START_BYTE = 8'h01;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [7:0] GC_PROG_CMD = 8'h04;
  localparam logic [1:0] GCK_NONE = 2'h0;
  localparam logic [1:0] GCK_RESET = 2'h1;
  localparam logic [1:0] GCK_PROG = 2'h2;
  localparam logic [1:0] GCK_ALT = 2'h3;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [2:0]
  {
    ISS_IDLE = 3'h0,
    ISS_ADDR = 3'h1,
    ISS_ACK = 3'h3,
    ISS_DATA = 3'h2,
    ISS_DACK = 3'h6,
    ISS_WAIT = 3'h4
  } iss_state_e;
endpackage

// ==== hdl/iss_status_upper.sv ====
`timescale 1ns/1ps
// Summary of operation
// - With slave enable set, set start flag on start plus address matching any slot.
// - Set start flag also when the start byte 0x01 arrives.
// - With general call enabled, set start flag on code 0x00.
// - Stop condition clears the start flag.
// - Set repeated start flag on every repeated start.
// - Stop or a status read clears the repeated start flag.
// - Report matching slot index in bits 12 to 11.
// - Set stop-after-start flag on stop after an addressed start.
// - Stop-after-start raises an interrupt when stop interrupt enable is one.
// - A status read clears the stop-after-start flag.
// - Bits 9 to 8 encode the general call kind received.
// - General call reset leaves the general call kind untouched.
// - General call reset returns other registers to defaults; interrupt status takes the new events.
// - Acknowledge general calls only when general call enable is set.
module iss_status_upper
  import iss_pkg::*;
#(
  parameter int NUM_SLOTS = 4
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ISS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen,
  output logic irq
);
  // ---------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ---------------------------------------------------------------
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // ---------------------------------------------------------------
  // Register storage and APB decode
  // ---------------------------------------------------------------
  logic [CTL_W-1:0] ctrl;
  logic [6:0] slot [NUM_SLOTS];
  logic [6:0] alt_id;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  logic sta, reps, ss, addressed, bus_active;
  logic [1:0] slot_idx, gc_kind;
  logic gc_rst, gc_evt;
  logic acc, wr_en, rd_done, kind_clr;
  logic [15:0] status_word;
  assign acc = psel & penable & pready;
  assign wr_en = acc & pwrite;
  assign rd_done = acc & ~pwrite & (paddr == OFS_STATUS);
  assign kind_clr = wr_en & (paddr == OFS_CONTROL) & pwdata[CTL_GC_CLR];
  assign status_word = {1'b0, sta, reps, slot_idx, ss, gc_kind, 8'h00};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  logic [31:0] next_rdata;
  logic next_err;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == OFS_STATUS)
      next_rdata = {16'h0000, status_word};
    else if (paddr == OFS_CONTROL)
      next_rdata = {29'h0000_0000, ctrl};
    else if (paddr == OFS_ALT_ID)
      next_rdata = {25'h000_0000, alt_id};
    else if (paddr == OFS_IRQ_STAT)
      next_rdata = {29'h0000_0000, irq_stat};
    else if (paddr == OFS_IRQ_MASK)
      next_rdata = {29'h0000_0000, irq_mask};
    else if (paddr >= OFS_SLOT0 && paddr < OFS_SLOT0 + 8'(4 * NUM_SLOTS) && paddr[1:0] == 2'h0)
      next_rdata = {25'h000_0000, slot[2'(paddr[3:2] - OFS_SLOT0[3:2])]};
    else
      next_err = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end
    else
    begin
      pslverr <= 1'b0;
    end
  end

  // Control, slots and alternative ID
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= CTL_RST;
      alt_id <= SLOT_RST;
    end
    else if (gc_rst)
    begin
      ctrl <= CTL_RST;
      alt_id <= SLOT_RST;
    end
    else if (wr_en && paddr == OFS_CONTROL)
      ctrl <= pwdata[CTL_W-1:0];
    else if (wr_en && paddr == OFS_ALT_ID)
      alt_id <= pwdata[6:0];
  end

  logic [NUM_SLOTS-1:0] slot_hit;
  logic [7:0] shift;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++)
    begin : g_slot
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          slot[gi] <= SLOT_RST;
        else if (gc_rst)
          slot[gi] <= SLOT_RST;
        else if (wr_en && paddr == OFS_SLOT0 + 8'(4 * gi))
          slot[gi] <= pwdata[6:0];
      end
      assign slot_hit[gi] = (shift[7:1] == slot[gi]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Byte receiver and acknowledge
  // ---------------------------------------------------------------
  iss_state_e state;
  logic [3:0] bit_cnt;
  logic addr_done, data_done, ack_on, gc_hit, addr_hit, sbyte_hit;
  logic [1:0] hit_idx;
  assign gc_hit = (shift == GC_ADDR) & ctrl[CTL_GC_EN];
  assign sbyte_hit = (shift == START_BYTE);
  // Code 0x00 is never a plain address, even if a slot holds zero
  assign addr_hit = ctrl[CTL_SLV_EN] & (|slot_hit) & (shift != GC_ADDR) & ~sbyte_hit;

  always_comb
  begin
    hit_idx = 2'h0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--)
      if (slot_hit[i])
        hit_idx = 2'(i);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ISS_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      addr_done <= 1'b0;
      data_done <= 1'b0;
      ack_on <= 1'b0;
      sda_oen <= 1'b1;
    end
    else if (start_det)
    begin
      state <= ISS_ADDR;
      bit_cnt <= 4'h0;
      addr_done <= 1'b0;
      data_done <= 1'b0;
      ack_on <= 1'b0;
      sda_oen <= 1'b1;
    end
    else if (stop_det)
    begin
      state <= ISS_IDLE;
      addr_done <= 1'b0;
      data_done <= 1'b0;
      ack_on <= 1'b0;
      sda_oen <= 1'b1;
    end
    else
    begin
      addr_done <= 1'b0;
      data_done <= 1'b0;
      case (state)
        ISS_ADDR, ISS_DATA:
        begin
          if (scl_rise && bit_cnt <= LAST_BIT)
          begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
            addr_done <= (bit_cnt == LAST_BIT) && (state == ISS_ADDR);
            data_done <= (bit_cnt == LAST_BIT) && (state == ISS_DATA);
          end
          if (addr_done)
            state <= (addr_hit | gc_hit) ? ISS_ACK : ISS_WAIT;
          if (data_done)
            state <= ISS_DACK;
        end
        ISS_ACK, ISS_DACK:
        begin
          if (scl_fall && !ack_on)
          begin
            ack_on <= 1'b1;
            sda_oen <= 1'b0;
          end
          else if (scl_fall)
          begin
            ack_on <= 1'b0;
            sda_oen <= 1'b1;
            bit_cnt <= 4'h0;
            state <= (state == ISS_ACK && shift == GC_ADDR) ? ISS_DATA : ISS_WAIT;
          end
        end
        ISS_WAIT, ISS_IDLE:
          state <= state;
        default:
          state <= ISS_IDLE;
      endcase
    end
  end
  assign sda_o = 1'b0;

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sta <= 1'b0;
      reps <= 1'b0;
      ss <= 1'b0;
      slot_idx <= 2'h0;
      addressed <= 1'b0;
      bus_active <= 1'b0;
    end
    else if (gc_rst)
    begin
      sta <= 1'b0;
      reps <= 1'b0;
      ss <= 1'b0;
      slot_idx <= 2'h0;
      addressed <= 1'b0;
    end
    else
    begin
      if (start_det)
        bus_active <= 1'b1;
      else if (stop_det)
        bus_active <= 1'b0;
      if (addr_done && (addr_hit || sbyte_hit || gc_hit))
        sta <= 1'b1;
      else if (stop_det)
        sta <= 1'b0;
      if (start_det && bus_active)
        reps <= 1'b1;
      else if (stop_det || (rd_done && prdata[REPS_BIT]))
        reps <= 1'b0;
      if (addr_done && addr_hit)
      begin
        slot_idx <= hit_idx;
        addressed <= 1'b1;
      end
      else if (stop_det)
        addressed <= 1'b0;
      if (stop_det && addressed)
        ss <= 1'b1;
      else if (rd_done && prdata[SS_BIT])
        ss <= 1'b0;
    end
  end

  // General call kind survives the general call reset
  logic [1:0] next_kind;
  always_comb
  begin
    next_kind = GCK_NONE;
    if (shift == GC_RESET_CMD)
      next_kind = GCK_RESET;
    else if (shift == GC_PROG_CMD)
      next_kind = GCK_PROG;
    else if (shift[0] && shift[7:1] == alt_id)
      next_kind = GCK_ALT;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gc_kind <= GCK_NONE;
      gc_rst <= 1'b0;
      gc_evt <= 1'b0;
    end
    else
    begin
      gc_rst <= data_done && (shift == GC_RESET_CMD);
      gc_evt <= data_done && (next_kind != GCK_NONE);
      if (data_done && next_kind != GCK_NONE)
        gc_kind <= next_kind;
      else if (kind_clr)
        gc_kind <= GCK_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, mask and output
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  assign irq_set[IRQ_SS] = stop_det & addressed & ~gc_rst & ctrl[CTL_STOP_IE];
  assign irq_set[IRQ_REPS] = start_det & bus_active & ~gc_rst;
  assign irq_set[IRQ_GC] = gc_evt;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_stat <= IRQ_RST;
      irq_mask <= IRQ_RST;
      irq <= 1'b0;
    end
    else
    begin
      if (gc_rst)
      begin
        irq_stat <= irq_set;
        irq_mask <= IRQ_RST;
      end
      else
      begin
        if (wr_en && paddr == OFS_IRQ_STAT)
          irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
        else
          irq_stat <= irq_stat | irq_set;
        if (wr_en && paddr == OFS_IRQ_MASK)
          irq_mask <= pwdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_START_ADDR: assert property (@(posedge sys_clk) disable iff (!rstn)
    addr_done && addr_hit && !gc_rst |=> sta)
    else $error("start flag not set on address match");
  AST_START_BYTE: assert property (@(posedge sys_clk) disable iff (!rstn)
    addr_done && shift == START_BYTE && !gc_rst |=> sta && !sda_oen == 1'b0)
    else $error("start byte not flagged");
  AST_GC_START: assert property (@(posedge sys_clk) disable iff (!rstn)
    addr_done && gc_hit && !gc_rst |=> sta ##0 state == ISS_ACK)
    else $error("general call not flagged");
  AST_STOP_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
    stop_det && !addr_done |=> !sta)
    else $error("start flag kept after stop");
  AST_REPS_SET: assert property (@(posedge sys_clk) disable iff (!rstn)
    start_det && bus_active && !gc_rst |=> reps ##0 irq_stat[IRQ_REPS])
    else $error("repeated start missed");
  AST_REPS_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_done && prdata[REPS_BIT] && !start_det |=> !reps)
    else $error("repeated start not cleared by read");
  AST_SLOT_IDX: assert property (@(posedge sys_clk) disable iff (!rstn)
    addr_done && addr_hit && !gc_rst |=> slot_idx == $past(hit_idx))
    else $error("slot index wrong");
  AST_SS_SET: assert property (@(posedge sys_clk) disable iff (!rstn)
    stop_det && addressed && !gc_rst |=> ss && !addressed)
    else $error("stop after start missed");
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(ss) && $past(ctrl[CTL_STOP_IE]) && irq_mask[IRQ_SS] |=> irq)
    else $error("stop interrupt missing");
  AST_SS_CLR: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_done && prdata[SS_BIT] && !(stop_det && addressed) |=> !ss)
    else $error("stop flag not cleared by read");
  AST_KIND_KEEP: assert property (@(posedge sys_clk) disable iff (!rstn)
    gc_rst && !kind_clr |=> gc_kind == $past(gc_kind))
    else $error("general call kind lost on reset");
  AST_RST_DEF: assert property (@(posedge sys_clk) disable iff (!rstn)
    gc_rst |=> ctrl == CTL_RST && alt_id == SLOT_RST && !sta)
    else $error("registers not defaulted by general call reset");
  AST_GC_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    addr_done && shift == GC_ADDR && !ctrl[CTL_GC_EN] |=> state != ISS_ACK)
    else $error("general call acknowledged while disabled");
  AST_RSVD: assert property (@(posedge sys_clk) disable iff (!rstn)
    pready && paddr == OFS_STATUS |-> prdata[31:15] == 17'h00000)
    else $error("reserved status bits not zero");
endmodule

// ==== test/iss_i2c_host.sv ====
`timescale 1ns/1ps
module iss_i2c_host
(
  output logic scl,
  output logic sda_rel,
  input wire logic sda_bus
);
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // ------------------------------------------
  // Bus phases, a quarter of a 160 ns bit each
  // ------------------------------------------
  // Changes land on a system clock edge, so drive them non-blocking
  task automatic step(input logic c, input logic d);
    scl <= c;
    sda_rel <= d;
    #40;
  endtask

  // Keeps SCL high if idle, so no stray edge
  task automatic start_cond();
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask

  task automatic stop_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  task automatic put_bit(input logic b);
    step(1'b0, b);
    step(1'b1, b);
    step(1'b1, b);
    step(1'b0, b);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    ack = ~sda_bus;
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
endmodule

// ==== test/test_iss_status_upper.sv ====
`timescale 1ns/1ps
module test_iss_status_upper
  import iss_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ISS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl;
  logic sda_rel;
  logic sda_o;
  logic sda_oen;
  logic irq;
  wire logic sda_bus;
  logic [31:0] rdat;
  logic rerr;
  logic ack;
  int bad_count = 0;
  int checked = 0;

  // Open-drain SDA with pull-up
  assign sda_bus = sda_rel & (sda_oen | sda_o);

  iss_status_upper #(.NUM_SLOTS(4)) i_dut
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .scl_i(scl),
    .sda_i(sda_bus),
    .sda_o(sda_o),
    .sda_oen(sda_oen),
    .irq(irq)
  );

  iss_i2c_host i_host
  (
    .scl(scl),
    .sda_rel(sda_rel),
    .sda_bus(sda_bus)
  );

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------
  // Bus access and comparison
  // ------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      bad_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #500us;
    bad_count++;
    results();
  end

  // ------------------------------------------
  // Test sequence
  // ------------------------------------------
  initial
  begin
    idle(3);
    rstn <= 1'b1;
    idle(4);
    wr(OFS_STATUS, 32'hFFFF);
    rd(OFS_STATUS);
    check(rdat, 32'h0);
    rd(8'hFC);
    check({31'h0, rerr}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
      wr(8'(OFS_SLOT0 + 4 * i), 32'(32'h10 + i));
    wr(OFS_CONTROL, 32'h7);
    wr(OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      i_host.start_cond();
      i_host.send_byte(8'(8'h20 + 2 * i), ack);
      rd(OFS_STATUS);
      check(rdat & 32'h7800, 32'(32'h4000 | (i << 11)));
      i_host.stop_cond();
      idle(4);
      check({31'h0, irq}, 32'h1);
      rd(OFS_STATUS);
      check(rdat & 32'h4400, 32'h0400);
      rd(OFS_STATUS);
      check(rdat & 32'h0400, 32'h0);
      wr(OFS_IRQ_STAT, 32'h7);
      idle(3);
      check({31'h0, irq}, 32'h0);
    end
    $display("test slots done");
    i_host.start_cond();
    i_host.send_byte(8'hAA, ack);
    check({31'h0, ack}, 32'h0);
    rd(OFS_STATUS);
    check(rdat & 32'h4000, 32'h0);
    i_host.stop_cond();
    idle(4);
    rd(OFS_STATUS);
    check(rdat & 32'h0400, 32'h0);
    $display("test nomatch done");
    i_host.start_cond();
    i_host.send_byte(8'h22, ack);
    i_host.start_cond();
    rd(OFS_STATUS);
    check(rdat & 32'h6000, 32'h6000);
    rd(OFS_STATUS);
    check(rdat & 32'h2000, 32'h0);
    i_host.start_cond();
    i_host.send_byte(8'h22, ack);
    i_host.stop_cond();
    idle(4);
    rd(OFS_STATUS);
    check(rdat & 32'h6000, 32'h0);
    wr(OFS_IRQ_STAT, 32'h7);
    $display("test repstart done");
    i_host.start_cond();
    i_host.send_byte(START_BYTE, ack);
    rd(OFS_STATUS);
    check(rdat & 32'h4000, 32'h4000);
    i_host.stop_cond();
    idle(4);
    $display("test startbyte done");
    i_host.start_cond();
    i_host.send_byte(GC_ADDR, ack);
    check({31'h0, ack}, 32'h1);
    rd(OFS_STATUS);
    check(rdat & 32'h4000, 32'h4000);
    i_host.send_byte(GC_PROG_CMD, ack);
    i_host.stop_cond();
    rd(OFS_STATUS);
    check(rdat & 32'h0300, 32'h0200);
    wr(OFS_ALT_ID, 32'h2A);
    i_host.start_cond();
    i_host.send_byte(GC_ADDR, ack);
    i_host.send_byte(8'h55, ack);
    i_host.stop_cond();
    rd(OFS_STATUS);
    check(rdat & 32'h0300, 32'h0300);
    wr(OFS_CONTROL, 32'hF);
    rd(OFS_STATUS);
    check(rdat & 32'h0300, 32'h0);
    i_host.start_cond();
    i_host.send_byte(GC_ADDR, ack);
    i_host.send_byte(GC_RESET_CMD, ack);
    i_host.stop_cond();
    rd(OFS_STATUS);
    check(rdat & 32'h0300, 32'h0100);
    rd(OFS_CONTROL);
    check(rdat, 32'h0);
    rd(OFS_SLOT0);
    check(rdat, 32'h0);
    rd(OFS_IRQ_MASK);
    check(rdat, 32'h0);
    i_host.start_cond();
    i_host.send_byte(GC_ADDR, ack);
    check({31'h0, ack}, 32'h0);
    rd(OFS_STATUS);
    check(rdat & 32'h4000, 32'h0);
    i_host.stop_cond();
    idle(4);
    $display("test gencall done");
    results();
  end
endmodule
